// ---- bench/nsx_exec_tb.sv ----
// self-checking bench for the nibble swap / xor / zero test execute block
`timescale 1ns/1ps
`default_nettype none
module nsx_exec_tb;
  import nsx_pkg::*;
  logic              core_clk    = 1'b0; // 50 MHz core clock
  logic              rst         = 1'b1; // reset from time zero
  logic              ce          = 1'b0; // clock enable
  logic              instr_valid = 1'b0; // request qualifier
  logic [OPC_W-1:0]  opcode      = '0;   // instruction word
  logic [DATA_W-1:0] reg_rdata   = '0;   // bench plays the register file
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, acc;
  logic              reg_we, zero_flag, zero_we, instr_done;
  // model: what the outputs must show after the coming edge
  logic [DATA_W-1:0] m_acc = ACC_RESET, m_wdata = '0, res;
  logic [ADDR_W-1:0] m_addr = '0;
  logic              m_z = 0, m_we = 0, m_zwe = 0, m_done = 0;
  logic [5:0]        tops [5] = '{TOP_SWAP, TOP_XORF, TOP_XORL, 6'h08, 6'h3f};
  int                n_errors = 0, cmp_count = 0, seed = 18, k;

  // free-running clock, 20 ns period
  always #10 core_clk = ~core_clk;

  nsx_exec dut (.core_clk(core_clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .opcode(opcode), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .acc(acc), .zero_flag(zero_flag), .zero_we(zero_we),
    .instr_done(instr_done));

  // count one comparison, report a mismatch at once
  task automatic chk(input logic ok, input string what);
    cmp_count++;
    if (!ok)
    begin
      n_errors++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask : chk

  // drive one cycle, check the previous cycle's outcome, then predict this one
  task automatic step(input logic r, c, v, input logic [OPC_W-1:0] o,
                      input logic [DATA_W-1:0] rd);
    @(posedge core_clk);
    rst <= r;
    ce <= c;
    instr_valid <= v;
    opcode <= o;
    reg_rdata <= rd;
    #1;
    chk(acc === m_acc, "acc");
    chk(zero_flag === m_z, "zero flag");
    chk(zero_we === m_zwe, "zero strobe");
    chk(instr_done === m_done, "done");
    chk(reg_we === m_we, "write strobe");
    if (m_we === 1'b1)
    begin
      chk(reg_wdata === m_wdata, "write data");
      chk(reg_addr === m_addr, "write address");
    end
    // reset wins over the enable; a low enable freezes pulses too
    if (r)
    begin
      m_acc = ACC_RESET;
      m_z = 0;
      {m_we, m_zwe, m_done} = 3'b000;
    end
    else if (c)
    begin
      {m_we, m_zwe, m_done} = 3'b000;
      if (v && o[13:8] == TOP_XORL)
      begin
        m_acc = m_acc ^ o[7:0];
        m_z = (m_acc == ZERO_BYTE);
        {m_zwe, m_done} = 2'b11;
      end
      else if (v && (o[13:8] == TOP_SWAP || o[13:8] == TOP_XORF))
      begin
        res = (o[13:8] == TOP_SWAP) ? {rd[3:0], rd[7:4]} : m_acc ^ rd;
        if (o[13:8] == TOP_XORF)
        begin
          m_z = (res == ZERO_BYTE);
          m_zwe = 1;
        end
        if (o[DIR_BIT])
        begin
          m_we = 1;
          m_wdata = res;
          m_addr = o[ADDR_W-1:0];
        end
        else
          m_acc = res;
        m_done = 1;
      end
      else if (v && o[13:7] == TOP_ZCHK)
      begin
        m_z = (rd == ZERO_BYTE);
        {m_zwe, m_done} = 2'b11;
      end
    end
  endtask : step

  // print counts and the verdict, then stop
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // main sequence: reset, directed walk, then random back-to-back traffic
  initial
  begin
    repeat (5) step(1, 0, 0, '0, '0);
    step(0, 1, 1, 14'h0e85, 8'ha5);
    step(0, 1, 1, {6'h1f, 8'hb5}, 8'h00);
    step(0, 1, 1, {6'h1f, 8'haf}, 8'h00);
    step(0, 1, 1, {6'h1f, 8'h1a}, 8'h00);
    step(0, 1, 1, {7'h11, 7'h7f}, 8'h00);
    step(0, 1, 1, {7'h11, 7'h00}, 8'h01);
    step(0, 1, 1, {7'h10, 7'h00}, 8'h00);
    step(0, 1, 1, {6'h06, 1'b0, 7'h12}, 8'h3c);
    step(0, 1, 1, {6'h06, 1'b1, 7'h12}, 8'h3c);
    step(0, 1, 1, 14'h0e00, 8'h5a);
    $display("test directed done");
    // a one-cycle reset at the midpoint, taken even with the enable low
    for (int i = 0; i < 600; i++)
    begin
      k = $unsigned($random(seed)) % 5;
      step(i == 300, ($random(seed) & 7) != 0, ($random(seed) & 3) != 0,
           {tops[k], 8'($random(seed))}, 8'($random(seed)));
    end
    $display("test random done");
    step(0, 1, 0, '0, '0);
    complete_run();
  end

  // cut a hang short well beyond the expected ~620 cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule : nsx_exec_tb
`default_nettype wire

// ---- rtl/nsx_dec_if.sv ----
// interface carrying decoded fields from decoder to executer
`timescale 1ns/1ps
`default_nettype none
interface nsx_dec_if;
  import nsx_pkg::*;
  nsx_op_e            op;        // decoded operation
  logic [ADDR_W-1:0]  addr;      // register address
  logic               dir;       // direction bit
  logic [DATA_W-1:0]  lit;       // literal field
  modport dec (output op, addr, dir, lit);
  modport exe (input op, addr, dir, lit);
endinterface : nsx_dec_if
`default_nettype wire

// ---- rtl/nsx_decode.sv ----
// combinational opcode decoder for the four supported instructions
`timescale 1ns/1ps
`default_nettype none
module nsx_decode
  import nsx_pkg::*;
(
  input  wire logic [OPC_W-1:0] opcode,
  nsx_dec_if.dec                d
);
  // classify opcode and split fields
  always_comb
  begin
    d.addr = opcode[ADDR_LSB +: ADDR_W];
    d.dir  = opcode[DIR_BIT];
    d.lit  = opcode[DATA_W-1:0];
    if (opcode[13:8] == TOP_XORL)
      d.op = NSX_OP_XORL;
    else if (opcode[13:7] == TOP_ZCHK)
      d.op = NSX_OP_ZCHK;
    else if (opcode[13:8] == TOP_SWAP)
      d.op = NSX_OP_SWAP;
    else if (opcode[13:8] == TOP_XORF)
      d.op = NSX_OP_XORF;
    else
      d.op = NSX_OP_NONE;
  end
endmodule : nsx_decode
`default_nettype wire

// ---- rtl/nsx_exec.sv ----
// execute stage: swap, zero test and xor with registered results
`timescale 1ns/1ps
`default_nettype none
module nsx_exec
  import nsx_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              ce,          // clock enable, freezes all state except under rst
  input  wire logic              instr_valid, // opcode is present this cycle
  input  wire logic [OPC_W-1:0]  opcode,      // fetched instruction
  input  wire logic [DATA_W-1:0] reg_rdata,   // addressed register contents
  output logic      [ADDR_W-1:0] reg_addr,    // registered address (write)
  output logic      [DATA_W-1:0] reg_wdata,   // write-back value
  output logic                   reg_we,      // one-cycle write strobe
  output logic      [DATA_W-1:0] acc,         // working accumulator
  output logic                   zero_flag,   // zero status flag
  output logic                   zero_we,     // pulse when zero flag updated
  output logic                   instr_done   // pulse one cycle after accept
);
  nsx_dec_if dif ();
  // field split and operation class
  nsx_decode u_dec
  (
    .opcode (opcode),
    .d      (dif)
  );

  // next-state values, registered by the clocked process below
  logic [DATA_W-1:0] next_acc;       // next accumulator
  logic              next_zero;      // next zero flag
  logic              next_zero_we;   // next zero update strobe
  logic [DATA_W-1:0] next_wdata;     // next write data
  logic              next_we;        // next write strobe
  logic [ADDR_W-1:0] next_addr;      // next write address
  logic              next_done;      // next completion pulse
  logic [DATA_W-1:0] swapped;        // nibble-exchanged operand
  logic [DATA_W-1:0] xr;             // xor result

  // compute results; every accepted op completes in one cycle
  always_comb
  begin
    swapped      = {reg_rdata[3:0], reg_rdata[7:4]};
    xr           = (dif.op == NSX_OP_XORL) ? (acc ^ dif.lit) : (acc ^ reg_rdata);
    next_acc     = acc;
    next_zero    = zero_flag;
    next_zero_we = 1'b0;
    next_wdata   = reg_wdata;
    next_we      = 1'b0;
    next_addr    = reg_addr;
    next_done    = 1'b0;
    // nothing is taken without a valid word
    if (instr_valid)
    begin
      next_done = (dif.op != NSX_OP_NONE);
      next_addr = dif.addr;
      case (dif.op)
        NSX_OP_SWAP:
        begin
          // flags untouched on swap
          if (dif.dir)
          begin
            next_wdata = swapped;
            next_we    = 1'b1;
          end
          else
            next_acc = swapped;
        end
        NSX_OP_ZCHK:
        begin
          // no data written: register and accumulator stay put
          next_zero    = (reg_rdata == ZERO_BYTE);
          next_zero_we = 1'b1;
        end
        // literal sits in the low byte; the register read is ignored
        NSX_OP_XORL:
        begin
          next_acc     = xr;
          next_zero    = (xr == ZERO_BYTE);
          next_zero_we = 1'b1;
        end
        // the flag follows the result whichever way it goes
        NSX_OP_XORF:
        begin
          next_zero    = (xr == ZERO_BYTE);
          next_zero_we = 1'b1;
          if (dif.dir)
          begin
            next_wdata = xr;
            next_we    = 1'b1;
          end
          else
            next_acc = xr;
        end
        // unknown words finish nothing; the address still follows the word
        default:
        begin
          next_done = 1'b0;
        end
      endcase
    end
  end

  // register state; ce low holds everything unless rst is high
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // synchronous reset: accumulator, flag and strobes to idle
      acc        <= ACC_RESET;
      zero_flag  <= 1'b0;
      zero_we    <= 1'b0;
      reg_wdata  <= ZERO_BYTE;
      reg_we     <= 1'b0;
      reg_addr   <= '0;
      instr_done <= 1'b0;
    end
    // reset wins over the enable so a frozen core can still be cleared
    else if (ce)
    begin
      acc        <= next_acc;
      zero_flag  <= next_zero;
      zero_we    <= next_zero_we;
      reg_wdata  <= next_wdata;
      reg_we     <= next_we;
      reg_addr   <= next_addr;
      instr_done <= next_done;
    end
  end

  // checks: named sequences for the multi-step behaviours
  sequence s_swap_wb;
    ce && instr_valid && dif.op == NSX_OP_SWAP && dif.dir;
  endsequence

  // register xor whose result returns to the register file
  sequence s_xorf_wb;
    ce && instr_valid && dif.op == NSX_OP_XORF && dif.dir;
  endsequence

  // enabled edge whose word matches none of the four operations
  sequence s_refused;
    ce && instr_valid && dif.op == NSX_OP_NONE;
  endsequence

  // enabled edge with no word offered
  sequence s_idle;
    ce && !instr_valid;
  endsequence

  // swap back to memory: nibbles exchanged in the write data
  a_swap_write_back: assert property (@(posedge core_clk) disable iff (rst)
    s_swap_wb |=> reg_we && reg_wdata == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])})
    else $error("swap write-back wrong");
  // swap into the accumulator, no write strobe
  a_swap_acc_value: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_SWAP && !dif.dir
    |=> acc == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])} && !reg_we)
    else $error("swap to accumulator wrong");
  a_swap_flag_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_SWAP |=> $stable(zero_flag) && !zero_we)
    else $error("swap changed zero flag");
  // swap back to memory leaves the accumulator alone
  a_swap_acc_hold: assert property (@(posedge core_clk) disable iff (rst)
    s_swap_wb |=> $stable(acc) && instr_done)
    else $error("swap write-back disturbed accumulator");
  // zero test on a zero operand
  a_zchk_zero_set: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_ZCHK && reg_rdata == ZERO_BYTE |=> zero_flag)
    else $error("zero test did not set flag");
  a_zchk_no_write: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_ZCHK
    |=> !reg_we && $stable(acc) && zero_flag == ($past(reg_rdata) == ZERO_BYTE))
    else $error("zero test result or side effect wrong");
  // a nonzero operand clears the flag and still strobes it
  a_zchk_zero_clear: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_ZCHK && reg_rdata != ZERO_BYTE
    |=> !zero_flag && zero_we && instr_done)
    else $error("zero test did not clear flag");
  // literal xor result and flag
  a_xorl_acc_value: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_XORL
    |=> acc == ($past(acc) ^ $past(opcode[7:0])) && zero_flag == (acc == ZERO_BYTE))
    else $error("literal xor wrong");
  // literal xor never touches the register file
  a_xorl_no_write: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_XORL |=> !reg_we && zero_we && instr_done)
    else $error("literal xor strobes wrong");
  a_xorf_dest_sel: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_XORF
    |=> reg_we == $past(opcode[DIR_BIT]) && zero_we)
    else $error("register xor destination wrong");
  // register xor into the accumulator
  a_xorf_acc_value: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op == NSX_OP_XORF && !dif.dir
    |=> acc == ($past(acc) ^ $past(reg_rdata)) && !reg_we && zero_flag == (acc == ZERO_BYTE))
    else $error("register xor to accumulator wrong");
  // register xor back to memory: value, flag, accumulator untouched
  a_xorf_write_back: assert property (@(posedge core_clk) disable iff (rst)
    s_xorf_wb |=> reg_we && reg_wdata == ($past(acc) ^ $past(reg_rdata)) && $stable(acc)
    && zero_flag == (reg_wdata == ZERO_BYTE))
    else $error("register xor write-back wrong");
  a_addr_field: assert property (@(posedge core_clk) disable iff (rst)
    ce && instr_valid && dif.op != NSX_OP_NONE |=> reg_addr == $past(opcode[6:0]) && instr_done)
    else $error("address field or completion wrong");
  // words outside the four operations change nothing but the address
  a_refused_no_effect: assert property (@(posedge core_clk) disable iff (rst)
    s_refused |=> !instr_done && !reg_we && !zero_we && $stable(acc) && $stable(zero_flag))
    else $error("unknown word had an effect");
  // no word offered: no strobes and no data change
  a_idle_no_pulse: assert property (@(posedge core_clk) disable iff (rst)
    s_idle |=> !instr_done && !reg_we && !zero_we && $stable(acc) && $stable(zero_flag))
    else $error("idle cycle had an effect");
  // a low enable freezes every registered output
  a_ce_freeze: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(acc) && $stable(zero_flag) && $stable(reg_we) && $stable(zero_we)
    && $stable(instr_done) && $stable(reg_wdata) && $stable(reg_addr))
    else $error("outputs moved while the enable was low");
  // reset clears the accumulator, the flag and every strobe
  a_reset_clear: assert property (@(posedge core_clk)
    rst |=> acc == ACC_RESET && !zero_flag && !reg_we && !zero_we && !instr_done)
    else $error("reset did not clear state");
endmodule : nsx_exec
`default_nettype wire

// ---- rtl/nsx_pkg.sv ----
// constants and types shared by the nibble swap / xor / zero test execute block
// Summary of operation
// - swap exchanges nibbles, flags untouched, one cycle
// - swap goes to accumulator, or register when d set
// - zero test sets zero flag when register zero
// - literal xor into accumulator, zero flag updated
// - register xor, zero flag, destination by d
// - address is opcode bits 6..0, d bit 7
package nsx_pkg;
  localparam int          OPC_W        = 14;        // instruction word width
  localparam int          DATA_W       = 8;         // data width
  localparam int          ADDR_W       = 7;         // register address width
  localparam int          DIR_BIT      = 7;         // direction bit position
  localparam int          ADDR_LSB     = 0;         // address field low bit
  localparam logic [5:0]  TOP_SWAP     = 6'h0e;     // 00 1110 d...
  localparam logic [5:0]  TOP_XORF     = 6'h06;     // 00 0110 d...
  localparam logic [5:0]  TOP_XORL     = 6'h1f;     // 01 1111 k...
  localparam logic [6:0]  TOP_ZCHK     = 7'h11;     // 00 1000 1...
  localparam logic [7:0]  ACC_RESET    = 8'h00;     // accumulator reset value
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;     // all-zero data
  // operation classes
  typedef enum logic [2:0]
  {
    NSX_OP_NONE  = 3'b000,
    NSX_OP_SWAP  = 3'b001,
    NSX_OP_ZCHK  = 3'b010,
    NSX_OP_XORL  = 3'b011,
    NSX_OP_XORF  = 3'b100
  } nsx_op_e;
endpackage : nsx_pkg
